// file: pgp_params.svh
// Purpose: Constants for the PROM programming port controller
// Assumes: 250 MHz ref_clk (4 ns period)
// Notes:   Times kept in their own unit; cycle counts derived from them
`ifndef PGP_PARAMS_SVH
`define PGP_PARAMS_SVH

`define PGP_CLK_NS          4
`define PGP_PULSE_NS        100000
`define PGP_PULSE_CYC       (`PGP_PULSE_NS / `PGP_CLK_NS)
`define PGP_SETUP_NS        100
`define PGP_SETUP_CYC       ((`PGP_SETUP_NS + `PGP_CLK_NS - 1) / `PGP_CLK_NS)
`define PGP_MAX_TRIES       4'ha
`define PGP_PAGE_BYTES      3'h4
`define PGP_LAST_ADDR       17'h0efff
`define PGP_ADDR_W          17
`define PGP_CNT_W           15

`endif

// file: pgp_pkg.sv
// Purpose: Types for the PROM programming port controller
// Assumes: Nothing beyond the params header
// Notes:   Commands and sequencer states
package pgp_pkg;
    typedef enum logic [1:0] {
        PGP_CMD_READ,
        PGP_CMD_BYTE,
        PGP_CMD_PAGE
    } pgp_cmd_type;

    typedef enum {
        PGP_IDLE,
        PGP_LATCH,
        PGP_PULSE,
        PGP_VERIFY,
        PGP_CHECK,
        PGP_READ,
        PGP_DONE
    } pgp_state_type;
endpackage

// file: pgp_timer_if.sv
// Purpose: Carrier between sequencer and its delay timer
// Assumes: Single clock domain
// Notes:   Start is a one-cycle pulse, expired a one-cycle pulse
`timescale 1ns/10ps
`default_nettype none
interface pgp_timer_if;
    logic        start;
    logic [14:0] load;
    logic        expired;
    modport seq (output start, output load, input expired);
    modport tmr (input start, input load, output expired);
endinterface
`default_nettype wire

// file: pgp_timer.sv
// Purpose: Down counter for strobe widths and setup delays
// Assumes: Loaded value of at least one cycle
// Notes:   Expired pulses once when count reaches one
`timescale 1ns/10ps
`default_nettype none
module pgp_timer (
    // Clock and reset
    input wire logic ref_clk,
    input wire logic sys_rst,
    // Control
    pgp_timer_if.tmr tmr
);
    logic [14:0] count_r;
    logic        run_r;
    logic        expired_r;

    ////////////////////////////////////////////////////////////////////
    // Count down; a new start restarts the count
    always_ff @(posedge ref_clk) begin
        if (sys_rst) begin
            count_r   <= 15'h0000;
            run_r     <= 1'b0;
            expired_r <= 1'b0;
        end else if (tmr.start) begin
            count_r   <= tmr.load;
            run_r     <= 1'b1;
            expired_r <= 1'b0;
        end else if (run_r && count_r <= 15'h0001) begin
            run_r     <= 1'b0;
            expired_r <= 1'b1;
        end else begin
            count_r   <= count_r - 15'h0001;
            expired_r <= 1'b0;
        end
    end

    assign tmr.expired = expired_r;
endmodule
`default_nettype wire

// file: pgp_host.sv
// Summary of operation
// - Hold reset low; raise supply for writes, normal level for reads only.
// - After latching, one 0.1 ms strobe with both enables high writes page.
// - Byte write is a 0.1 ms strobe, chip enable low, output enable high.
// - Failed location gets write and verify repeated, at most ten tries.
// - Verify with chip enable and output enable low, compare every write.
// - Read one of several devices by enabling only its outputs.
// - Write only addresses zero to the array top, last given explicitly.
// - Read: reset low, normal supply, address on 17 lines, sample data.
//
// Purpose: Programmer-side sequencer driving the PROM programming pins
// Assumes: User supplies data per address through a request/answer port
// Notes:   Device inputs pass two flops; all outputs are registered
`timescale 1ns/10ps
`default_nettype none
`include "pgp_params.svh"
module pgp_host #(
    parameter int PULSE_CYC = `PGP_PULSE_CYC
) (
    // Clock and reset
    input  wire logic        ref_clk,
    input  wire logic        sys_rst,
    // User command
    input  wire logic        cmdValid,
    input  wire logic [1:0]  cmdKind,
    input  wire logic [16:0] cmdStart,
    input  wire logic [16:0] cmdLast,
    input  wire logic [3:0]  devSel,
    // User data supply and read return
    output logic             dataReq,
    output logic [16:0]      dataAddr,
    input  wire logic [7:0]  dataIn,
    output logic             rdValid,
    output logic [7:0]       rdData,
    // Status
    output logic             busy,
    output logic             done,
    output logic             failed,
    output logic [16:0]      failAddr,
    // Device pins
    output logic             devRst_n,
    output logic             vppHigh,
    output logic [16:0]      addrOut,
    output logic [7:0]       dOut,
    output logic             dOe,
    input  wire logic [7:0]  dIn,
    output logic             chipEnable_n,
    output logic [3:0]       outputEnable_n,
    output logic [3:0]       program_strobe_n
);
    pgp_timer_if tif ();
    pgp_timer u_timer (
        .ref_clk(ref_clk),
        .sys_rst(sys_rst),
        .tmr    (tif.tmr)
    );

    pgp_pkg::pgp_state_type state_r;
    pgp_pkg::pgp_cmd_type   kind_r;
    logic [16:0] last_r;
    logic [3:0]  sel_r;
    logic [3:0]  tries_r;
    logic [2:0]  idx_r;
    logic [16:0] base_r;
    logic [7:0]  want_r [0:3];
    logic [7:0]  dSync1_r;
    logic [7:0]  dSync2_r;
    logic        tStart_r;
    logic [14:0] tLoad_r;
    logic        match;
    logic [2:0]  unitLen;

    assign tif.start = tStart_r;
    assign tif.load  = tLoad_r;
    // Bytes per unit: page of four or single byte
    assign unitLen = (kind_r == pgp_pkg::PGP_CMD_PAGE) ?
                     `PGP_PAGE_BYTES : 3'h1;
    assign match = (dSync2_r == want_r[idx_r[1:0]]);

    ////////////////////////////////////////////////////////////////////
    // Device data pins come from another domain
    always_ff @(posedge ref_clk) begin
        if (sys_rst) begin
            dSync1_r <= 8'h00;
            dSync2_r <= 8'h00;
        end else begin
            dSync1_r <= dIn;
            dSync2_r <= dSync1_r;
        end
    end

    ////////////////////////////////////////////////////////////////////
    // Sequencer; pin steps wait on the timer except in CHECK and DONE, which change pins in one cycle
    always_ff @(posedge ref_clk) begin
        if (sys_rst) begin
            state_r          <= pgp_pkg::PGP_IDLE;
            kind_r           <= pgp_pkg::PGP_CMD_READ;
            last_r           <= 17'h00000;
            sel_r            <= 4'h1;
            tries_r          <= 4'h0;
            idx_r            <= 3'h0;
            base_r           <= 17'h00000;
            tStart_r         <= 1'b0;
            tLoad_r          <= 15'h0000;
            dataReq          <= 1'b0;
            dataAddr         <= 17'h00000;
            rdValid          <= 1'b0;
            rdData           <= 8'h00;
            busy             <= 1'b0;
            done             <= 1'b0;
            failed           <= 1'b0;
            failAddr         <= 17'h00000;
            devRst_n         <= 1'b0;
            vppHigh          <= 1'b0;
            addrOut          <= 17'h00000;
            dOut             <= 8'h00;
            dOe              <= 1'b0;
            chipEnable_n     <= 1'b1;
            outputEnable_n   <= 4'hf;
            program_strobe_n <= 4'hf;
            for (int i = 0; i < 4; i++) begin
                want_r[i] <= 8'h00;
            end
        end else begin
            tStart_r <= 1'b0;
            dataReq  <= 1'b0;
            rdValid  <= 1'b0;
            done     <= 1'b0;
            devRst_n <= 1'b0;
            case (state_r)
                pgp_pkg::PGP_IDLE: begin
                    chipEnable_n     <= 1'b1;
                    outputEnable_n   <= 4'hf;
                    program_strobe_n <= 4'hf;
                    dOe              <= 1'b0;
                    busy             <= 1'b0;
                    // Writes beyond the array top are refused
                    if (cmdValid && !(cmdKind != 2'h0 &&
                        cmdLast > `PGP_LAST_ADDR)) begin
                        kind_r  <= pgp_pkg::pgp_cmd_type'(cmdKind);
                        base_r  <= cmdStart;
                        last_r  <= cmdLast;
                        sel_r   <= devSel;
                        failed  <= 1'b0;
                        busy    <= 1'b1;
                        idx_r   <= 3'h0;
                        tries_r <= 4'h0;
                        vppHigh <= (cmdKind != 2'h0);
                        state_r <= (cmdKind == 2'h0) ?
                                   pgp_pkg::PGP_READ :
                                   pgp_pkg::PGP_LATCH;
                        dataReq  <= (cmdKind != 2'h0);
                        dataAddr <= cmdStart;
                        tLoad_r  <= 15'(`PGP_SETUP_CYC);
                        tStart_r <= 1'b1;
                    end
                end
                pgp_pkg::PGP_READ: begin
                    // Only the chosen device drives the bus
                    addrOut        <= base_r;
                    chipEnable_n   <= 1'b0;
                    outputEnable_n <= ~sel_r;
                    if (tif.expired) begin
                        rdValid <= 1'b1;
                        rdData  <= dSync2_r;
                        if (base_r >= last_r) begin
                            state_r <= pgp_pkg::PGP_DONE;
                        end else begin
                            base_r   <= base_r + 17'h00001;
                            tStart_r <= 1'b1;
                        end
                    end
                end
                pgp_pkg::PGP_LATCH: begin
                    // One byte per setup slot; page latch needs CE high
                    addrOut <= base_r + 17'(idx_r);
                    dOut    <= dataIn;
                    dOe     <= 1'b1;
                    want_r[idx_r[1:0]] <= dataIn;
                    if (kind_r == pgp_pkg::PGP_CMD_PAGE) begin
                        // Only the target latches; others sit in standby
                        chipEnable_n   <= 1'b1;
                        outputEnable_n <= ~sel_r;
                    end else begin
                        chipEnable_n   <= 1'b0;
                        outputEnable_n <= 4'hf;
                    end
                    if (tif.expired) begin
                        tStart_r <= 1'b1;
                        if (idx_r + 3'h1 >= unitLen) begin
                            idx_r   <= 3'h0;
                            // Timer expiry takes one extra cycle to reach us
                            tLoad_r <= 15'(PULSE_CYC - 1);
                            state_r <= pgp_pkg::PGP_PULSE;
                        end else begin
                            idx_r    <= idx_r + 3'h1;
                            dataReq  <= 1'b1;
                            dataAddr <= base_r + 17'(idx_r) + 17'h00001;
                        end
                    end
                end
                pgp_pkg::PGP_PULSE: begin
                    // Unselected devices keep strobe high
                    outputEnable_n   <= 4'hf;
                    chipEnable_n     <= (kind_r == pgp_pkg::PGP_CMD_PAGE);
                    program_strobe_n <= ~sel_r;
                    if (tif.expired) begin
                        program_strobe_n <= 4'hf;
                        dOe      <= 1'b0;
                        tries_r  <= tries_r + 4'h1;
                        tLoad_r  <= 15'(`PGP_SETUP_CYC);
                        tStart_r <= 1'b1;
                        state_r  <= pgp_pkg::PGP_VERIFY;
                    end
                end
                pgp_pkg::PGP_VERIFY: begin
                    addrOut        <= base_r + 17'(idx_r);
                    chipEnable_n   <= 1'b0;
                    outputEnable_n <= ~sel_r;
                    if (tif.expired) begin
                        state_r <= pgp_pkg::PGP_CHECK;
                    end
                end
                pgp_pkg::PGP_CHECK: begin
                    tLoad_r  <= 15'(`PGP_SETUP_CYC);
                    tStart_r <= 1'b1;
                    if (!match) begin
                        outputEnable_n <= 4'hf;
                        if (tries_r >= `PGP_MAX_TRIES) begin
                            failed   <= 1'b1;
                            failAddr <= base_r + 17'(idx_r);
                            state_r  <= pgp_pkg::PGP_DONE;
                        end else begin
                            // Rewrite the unit, relatch first
                            idx_r    <= 3'h0;
                            dataReq  <= 1'b1;
                            dataAddr <= base_r;
                            state_r  <= pgp_pkg::PGP_LATCH;
                        end
                    end else if (idx_r + 3'h1 < unitLen) begin
                        idx_r   <= idx_r + 3'h1;
                        state_r <= pgp_pkg::PGP_VERIFY;
                    end else if (base_r + 17'(unitLen) > last_r) begin
                        state_r <= pgp_pkg::PGP_DONE;
                    end else begin
                        base_r   <= base_r + 17'(unitLen);
                        idx_r    <= 3'h0;
                        tries_r  <= 4'h0;
                        dataReq  <= 1'b1;
                        dataAddr <= base_r + 17'(unitLen);
                        outputEnable_n <= 4'hf;
                        state_r  <= pgp_pkg::PGP_LATCH;
                    end
                end
                pgp_pkg::PGP_DONE: begin
                    chipEnable_n   <= 1'b1;
                    outputEnable_n <= 4'hf;
                    dOe            <= 1'b0;
                    vppHigh        <= 1'b0;
                    done           <= 1'b1;
                    busy           <= 1'b0;
                    state_r        <= pgp_pkg::PGP_IDLE;
                end
                default: begin
                    state_r <= pgp_pkg::PGP_IDLE;
                end
            endcase
        end
    end
endmodule
`default_nettype wire

// file: pgp_host_monitor.sv
// Purpose: Port checker for the PROM programming controller
// Assumes: One clock, synchronous active-high reset
// Notes:   Strobe width follows the bound PULSE_CYC
`timescale 1ns/10ps
`default_nettype none
module pgp_host_checker #(
    parameter int PULSE_CYC = 20
) (
    // Clock and reset
    input wire logic        ref_clk,
    input wire logic        sys_rst,
    // User side
    input wire logic        cmdValid,
    input wire logic [1:0]  cmdKind,
    input wire logic [16:0] cmdStart,
    input wire logic [16:0] cmdLast,
    input wire logic [3:0]  devSel,
    input wire logic        dataReq,
    input wire logic [16:0] dataAddr,
    input wire logic        busy,
    input wire logic        failed,
    // Device pins
    input wire logic        devRst_n,
    input wire logic        vppHigh,
    input wire logic [16:0] addrOut,
    input wire logic        dOe,
    input wire logic        chipEnable_n,
    input wire logic [3:0]  outputEnable_n,
    input wire logic [3:0]  program_strobe_n
);
    logic        pulseLow;
    logic        take;
    logic        prevLow_r;
    logic        pageKind_r;
    int          lowCnt_r;
    int          tries_r;
    logic [16:0] unit;
    logic [16:0] unit_r;

    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (sys_rst);
    ////////////////////////////////////////
    // Unit key: a page shares one key, so a relatch is still one try
    assign pulseLow = program_strobe_n != 4'hf;
    assign take = cmdValid && !busy;
    assign unit = pageKind_r ? {dataAddr[16:2], 2'h0} : dataAddr;

    // Strobe width and command kind
    always_ff @(posedge ref_clk) begin
        lowCnt_r <= (sys_rst || !pulseLow) ? 0 : lowCnt_r + 1;
        prevLow_r <= pulseLow && !sys_rst;
        if (sys_rst) begin
            pageKind_r <= 1'b0;
        end else if (take) begin
            pageKind_r <= cmdKind == 2'h2;
        end
    end

    // Pulses spent on the current unit
    always_ff @(posedge ref_clk) begin
        unit_r <= dataReq ? unit : unit_r;
        if (sys_rst || take || (dataReq && unit != unit_r)) begin
            tries_r <= 0;
        end else if (pulseLow && !prevLow_r) begin
            tries_r <= tries_r + 1;
        end
    end
    ////////////////////////////////////////
    a_reset_low: assert property (!devRst_n)
        else $error("device reset released");
    a_strobe_vpp: assert property (pulseLow |-> vppHigh)
        else $error("strobe without raised supply");
    a_pulse_enables: assert property (pulseLow |->
        outputEnable_n == 4'hf && chipEnable_n == pageKind_r)
        else $error("wrong enables during strobe");
    a_pulse_width: assert property (
        $rose(!pulseLow) && !$past(sys_rst) |-> lowCnt_r == PULSE_CYC)
        else $error("strobe width wrong");
    a_strobe_selected: assert property (
        (~program_strobe_n & ~devSel) == 4'h0)
        else $error("strobe on unselected device");
    a_oe_selected: assert property (
        (~outputEnable_n & ~devSel) == 4'h0)
        else $error("output enable on unselected device");
    a_tries_bounded: assert property (tries_r <= 10)
        else $error("more than ten pulses on one unit");
    a_fail_at_ten: assert property ($rose(failed) |-> tries_r == 10)
        else $error("failure not after ten pulses");
    a_write_range: assert property (pulseLow |-> addrOut <= 17'h0efff)
        else $error("write above array top");
    a_read_vpp: assert property (take && cmdKind == 2'h0 |=>
        busy && !vppHigh) else $error("read with raised supply");
    a_verify_quiet: assert property (
        !chipEnable_n && outputEnable_n != 4'hf |-> !dOe)
        else $error("host drives bus during verify");
    a_take_request: assert property (
        take && cmdKind != 2'h0 && cmdLast <= 17'h0efff |=>
        dataReq && dataAddr == $past(cmdStart))
        else $error("no data request for start address");
    c_page_pulse: cover property (pulseLow && chipEnable_n);
    c_fail: cover property ($rose(failed));
    c_read: cover property (take && cmdKind == 2'h0);
endmodule
bind pgp_host pgp_host_checker #(.PULSE_CYC(PULSE_CYC)) u_chk (
    .ref_clk, .sys_rst, .cmdValid, .cmdKind, .cmdStart, .cmdLast,
    .devSel, .dataReq, .dataAddr, .busy, .failed, .devRst_n, .vppHigh,
    .addrOut, .dOe, .chipEnable_n, .outputEnable_n, .program_strobe_n);
`default_nettype wire

// file: pgp_prom_model.sv
// Purpose: Behavioural PROM device on the programming pins
// Assumes: Sampled on ref_clk; erased cells read all ones
// Notes:   First weakTries full pulses fail, later ones program
`timescale 1ns/10ps
`default_nettype none
module pgp_prom_model #(
    parameter int PULSE_CYC = 20
) (
    // Clock
    input wire logic        ref_clk,
    // Programming pins
    input wire logic        devRst_n,
    input wire logic        vppHigh,
    input wire logic [16:0] addr,
    input wire logic [7:0]  dBus,
    input wire logic        chipEnable_n,
    input wire logic        outputEnable_n,
    input wire logic        program_strobe_n,
    // Fault control and read data
    input wire logic [3:0]  weakTries,
    output logic [7:0]      q,
    output logic            drv
);
    logic [7:0]  mem [131072];
    logic [7:0]  pageLat [4];
    logic [14:0] pageBase;
    int          lowCnt = 0;
    int          pulses = 0;
    logic        prog;

    function automatic logic [7:0] rd(input logic [16:0] a);
        return mem[a];
    endfunction
    // Every cell starts erased
    initial foreach (mem[i]) mem[i] = 8'hff;
    ////////////////////////////////////////
    // Reset low selects programming; a raised supply allows writes
    assign prog = !devRst_n;
    // Drive only in read or verify; float in standby or disable
    assign drv = prog && !chipEnable_n && !outputEnable_n
        && program_strobe_n;

    // Data lags one cycle, so the host meets a slow answer
    always @(posedge ref_clk) begin
        q <= rd(addr);
        lowCnt <= program_strobe_n ? 0 : lowCnt + 1;
        if (prog && vppHigh && chipEnable_n && program_strobe_n
            && !outputEnable_n) begin
            pageLat[addr[1:0]] <= dBus;
            pageBase <= addr[16:2];
        end
        if (prog && vppHigh && outputEnable_n && !program_strobe_n
            && lowCnt == PULSE_CYC - 1) begin
            pulses <= pulses + 1;
            if (pulses >= weakTries && chipEnable_n) begin
                for (int k = 0; k < 4; k++)
                    mem[{pageBase, 2'(k)}] = rd({pageBase, 2'(k)}) & pageLat[k];
            end else if (pulses >= weakTries) begin
                mem[addr] = rd(addr) & dBus;
            end
        end
    end
endmodule
`default_nettype wire

// file: pgp_host_tb.sv
// Purpose: Self-checking bench for the PROM programming controller
// Assumes: Four device models share address, data and chip enable
// Notes:   Short strobe width keeps the run brief
`timescale 1ns/10ps
`default_nettype none
module pgp_host_tb;
    localparam int PULSE = 20;
    localparam logic [1:0] RD = pgp_pkg::PGP_CMD_READ;
    localparam logic [1:0] BW = pgp_pkg::PGP_CMD_BYTE;
    localparam logic [1:0] PW = pgp_pkg::PGP_CMD_PAGE;
    typedef struct packed {
        logic [1:0] kind; logic [16:0] start; logic [16:0] last;
        logic [3:0] sel; logic isPat;
    } pgp_row_type;
    logic        ref_clk = 0, sys_rst = 1, cmdValid = 0;
    logic        dataReq, rdValid, busy, done, failed, devRst_n, vppHigh;
    logic        dOe, chipEnable_n, curPat;
    logic [1:0]  cmdKind = 0;
    logic [3:0]  devSel = 0, outputEnable_n, program_strobe_n, drvV;
    logic [3:0]  prevStb = 4'hf, weakTries [4] = '{default: 4'h0};
    logic [7:0]  dataIn = 0, rdData, dOut, dIn, floatPat = 8'h5a, qV [4];
    logic [16:0] cmdStart = 0, cmdLast = 0, dataAddr, failAddr, addrOut;
    logic [16:0] curStart, rdCnt;
    int          mismatches = 0, samplesChecked = 0;
    int          pulseCount = 0, pulseBase;
    pgp_row_type rows [5] = '{
        '{BW, 17'h00010, 17'h00012, 4'h1, 1'b0},
        '{PW, 17'h0eff8, 17'h0efff, 4'h2, 1'b0},
        '{RD, 17'h00010, 17'h00012, 4'h1, 1'b1},
        '{RD, 17'h0eff8, 17'h0efff, 4'h2, 1'b1},
        '{RD, 17'h00010, 17'h00011, 4'h2, 1'b0}};

    pgp_host #(.PULSE_CYC(PULSE)) DUT (.ref_clk, .sys_rst, .cmdValid,
        .cmdKind, .cmdStart, .cmdLast, .devSel, .dataReq, .dataAddr,
        .dataIn, .rdValid, .rdData, .busy, .done, .failed, .failAddr,
        .devRst_n, .vppHigh, .addrOut, .dOut, .dOe, .dIn, .chipEnable_n,
        .outputEnable_n, .program_strobe_n);
    for (genvar k = 0; k < 4; k++) begin : g_dev
        pgp_prom_model #(.PULSE_CYC(PULSE)) u_dev (.ref_clk, .devRst_n,
            .vppHigh, .addr(addrOut), .dBus(dIn), .chipEnable_n,
            .outputEnable_n(outputEnable_n[k]), .weakTries(weakTries[k]),
            .program_strobe_n(program_strobe_n[k]), .q(qV[k]),
            .drv(drvV[k]));
    end
    ////////////////////////////////////////
    function automatic logic [7:0] pat(input logic [16:0] a);
        return a[7:0] ^ a[15:8] ^ 8'h3c;
    endfunction
    task automatic check_bit(input string nm, input logic e, input logic g);
        samplesChecked++;
        if (g !== e) begin
            mismatches++;
            $display("ERROR %s expected %h seen %h", nm, e, g);
        end
    endtask
    task automatic check_word(input string nm, input logic [16:0] e,
                              input logic [16:0] g);
        samplesChecked++;
        if (g !== e) begin
            mismatches++;
            $display("ERROR %s expected %h seen %h", nm, e, g);
        end
    endtask
    task automatic issue(input pgp_row_type r);
        curStart = r.start;
        curPat = r.isPat;
        rdCnt = 0;
        pulseBase = pulseCount;
        @(negedge ref_clk);
        {cmdKind, cmdStart, cmdLast, devSel} = {r.kind, r.start, r.last, r.sel};
        cmdValid = 1'b1;
        @(negedge ref_clk);
        cmdValid = 1'b0;
    endtask
    task automatic run_cmd(input pgp_row_type r);
        int n;
        n = 0;
        issue(r);
        while (done !== 1'b1 && failed !== 1'b1 && n < 20000) begin
            @(negedge ref_clk);
            n++;
        end
        check_bit("finished", 1'b1, done | failed);
    endtask
    task automatic stopTest();
        $display("checked %0d mismatches %0d", samplesChecked, mismatches);
        if (mismatches == 0 && samplesChecked > 0) $display("bench passed");
        else $display("bench failed");
        $finish;
    endtask
    ////////////////////////////////////////
    // Clock; a released bus toggles so stale data never matches
    initial forever #2 ref_clk = ~ref_clk;
    always @(posedge ref_clk) floatPat <= ~floatPat;
    always_comb begin
        dIn = floatPat;
        for (int k = 0; k < 4; k++) if (drvV[k]) dIn = qV[k];
        if (dOe) dIn = dOut;
    end
    // Data supply, read-back compare and strobe pulse count
    always @(negedge ref_clk) begin
        if (dataReq === 1'b1) dataIn <= pat(dataAddr);
        if (rdValid === 1'b1) begin
            check_word("rdData", 17'(curPat ? pat(curStart + rdCnt) : 8'hff),
                       17'(rdData));
            rdCnt++;
        end
        if (program_strobe_n != 4'hf && prevStb == 4'hf) pulseCount++;
        prevStb = program_strobe_n;
    end
    // Watchdog: the whole sequence needs far fewer cycles
    initial begin
        #300000;
        mismatches++;
        stopTest();
    end
    initial begin
        int n;
        repeat (3) @(negedge ref_clk);
        sys_rst = 1'b0;
        check_word("idle", 17'h7fc, 17'({chipEnable_n, outputEnable_n,
            program_strobe_n, dOe, vppHigh}));
        foreach (rows[i]) begin
            run_cmd(rows[i]);
            check_bit("failed", 1'b0, failed);
            if (rows[i].kind == RD)
                check_word("rdCount", rows[i].last - rows[i].start + 17'h1,
                           rdCnt);
        end
        // Device ignores three pulses: fourth attempt succeeds
        weakTries[2] = 4'h3;
        run_cmd('{BW, 17'h00100, 17'h00100, 4'h4, 1'b0});
        check_bit("failed", 1'b0, failed);
        check_word("pulses", 17'h4, 17'(pulseCount - pulseBase));
        run_cmd('{RD, 17'h00100, 17'h00100, 4'h4, 1'b1});
        // Device never programs: host gives up after ten
        weakTries[3] = 4'hf;
        run_cmd('{BW, 17'h00200, 17'h00200, 4'h8, 1'b0});
        check_bit("failed", 1'b1, failed);
        check_word("failAddr", 17'h00200, failAddr);
        check_word("pulses", 17'ha, 17'(pulseCount - pulseBase));
        // Last address past the array top: the whole command is refused
        issue('{PW, 17'h0effc, 17'h0f000, 4'h1, 1'b0});
        repeat (3) @(negedge ref_clk);
        check_bit("busy", 1'b0, busy);
        // Reset in mid-pulse: pins go idle, cell stays erased
        issue('{BW, 17'h00020, 17'h00020, 4'h1, 1'b0});
        n = 0;
        while (program_strobe_n === 4'hf && n < 500) begin
            @(negedge ref_clk);
            n++;
        end
        repeat (3) @(negedge ref_clk);
        check_word("strobe", 17'h0000e, 17'(program_strobe_n));
        sys_rst = 1'b1;
        @(negedge ref_clk);
        check_word("idle", 17'h7fc, 17'({chipEnable_n, outputEnable_n,
            program_strobe_n, dOe, vppHigh}));
        sys_rst = 1'b0;
        run_cmd('{RD, 17'h00020, 17'h00020, 4'h1, 1'b0});
        stopTest();
    end
endmodule
`default_nettype wire
